// >>> wdsw_top.sv
// watchdog, sleep entry and wake-up control with an APB register port
`timescale 1ns/10ps
`include "wdsw_defines.svh"

// How it works
// - watchdog counts its own oscillator ticks
// - expiry while running resets device
// - expiry during sleep wakes, no reset
// - every expiry clears expiry flag
// - fuse enable keeps watchdog always running
// - fuse off: soft bit switches watchdog
// - clear instruction or sleep entry zeroes counters
// - clear zeroes postscale count, keeps assignment
// - postscale ratio from fuse bits three-one
// - control bits seven-one read zero
// - sleep: clear watchdog and powerdown flag, set expiry flag, stop oscillator
// - pins hold their drive during sleep
// - master clear, watchdog, interrupts wake
// - only clockless sources wake from sleep
// - master clear resets, others continue
// - powerdown flag set at power-up
// - sleep prefetches program counter plus two
// - own enable wakes, global enable ignored
// - after wake, branch only if global
// - pending interrupt makes sleep a no-op
module wdsw_top #(
	parameter int BASE_PERIOD = 256,
	parameter int CNT_W       = 16,
	parameter int PC_W        = 21,
	parameter int IO_W        = 8
) (
	input  wire logic                   CORE_CLK,
	input  wire logic                   RESET_N,
	input  wire logic                   PSEL,
	input  wire logic                   PENABLE,
	input  wire logic                   PWRITE,
	input  wire logic [`WDSW_ADDR_W-1:0] PADDR,
	input  wire logic [31:0]            PWDATA,
	output logic      [31:0]            PRDATA,
	output logic                        PREADY,
	output logic                        PSLVERR,
	input  wire logic [7:0]             WATCHDOG_CONFIG_BYTE,
	input  wire logic                   WATCHDOG_OSC,
	input  wire logic                   MASTER_CLEAR_PIN_N,
	input  wire logic                   SLEEP_INSTR,
	input  wire logic                   WATCHDOG_CLEAR_INSTR,
	input  wire logic [PC_W-1:0]        PROGRAM_COUNTER,
	input  wire logic                   GLOBAL_IRQ_ENABLE,
	input  wire wdsw_pkg::wdsw_wake_type IRQ_FLAGS,
	input  wire wdsw_pkg::wdsw_wake_type IRQ_ENABLES,
	input  wire logic [IO_W-1:0]        IO_DRIVE_IN,
	input  wire logic [IO_W-1:0]        IO_OE_IN,
	output logic      [IO_W-1:0]        IO_DRIVE,
	output logic      [IO_W-1:0]        IO_OE,
	output logic      [PC_W-1:0]        PREFETCH_ADDR,
	output logic                        SLEEPING,
	output logic                        OSC_DRIVER_ON,
	output logic                        WATCHDOG_RESET,
	output logic                        MASTER_CLEAR_RESET,
	output logic                        WAKE,
	output logic                        WAKE_BRANCH,
	output logic                        SLEEP_NOP
);
	import wdsw_pkg::*;

	localparam int NPIN = 2;
	localparam int PIN_OSC = 0;
	localparam int PIN_MASTER_CLEAR_PIN = 1;

	logic                  rst_ff1;
	logic                  rst_n;
	logic [NPIN-1:0]       pin_raw;
	logic [NPIN-1:0]       pin_s1;
	logic [NPIN-1:0]       pin_s2;
	logic [NPIN-1:0]       pin_s3;
	logic [NPIN-1:0]       pin_level;
	logic [NPIN-1:0]       pin_prev;
	logic                  osc_tick;
	logic                  master_clear_pin_fall;
	logic [7:0]            fuse_cfg;
	logic                  soft_en;
	logic                  expiry_flag_n;
	logic                  powerdown_flag_n;
	wdsw_state_type        state;
	logic                  wdt_run;
	logic                  wdt_clear;
	logic                  wdt_expire;
	logic                  irq_pending;
	logic                  sleep_enter;
	logic                  sleep_wake;
	logic                  sleep_ignored;
	logic                  apb_write;
	logic                  apb_read;
	logic                  addr_hit;
	logic [7:0]            read_byte;

	// register address decode for the error answer; the read mux decodes PADDR itself
	function automatic logic is_mapped(input logic [`WDSW_ADDR_W-1:0] addr);
		is_mapped = (addr == `WDSW_OFF_CONTROL) || (addr == `WDSW_OFF_FUSE) ||
			(addr == `WDSW_OFF_CAUSE) || (addr == `WDSW_OFF_STATUS);
	endfunction

	// two-stage release so deassertion is clean against CORE_CLK
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_ff1 <= 1'b0;
			rst_n   <= 1'b0;
		end else begin
			rst_ff1 <= 1'b1;
			rst_n   <= rst_ff1;
		end
	end

	// pin inputs: three stages, a change counts once stages two and three agree
	assign pin_raw[PIN_OSC]  = WATCHDOG_OSC;
	assign pin_raw[PIN_MASTER_CLEAR_PIN] = MASTER_CLEAR_PIN_N;

	generate
		for (genvar i = 0; i < NPIN; i++) begin : g_pin
			always_ff @(posedge CORE_CLK or negedge rst_n) begin
				if (!rst_n) begin
					pin_s1[i] <= 1'b1;
					pin_s2[i] <= 1'b1;
					pin_s3[i] <= 1'b1;
				end else begin
					pin_s1[i] <= pin_raw[i];
					pin_s2[i] <= pin_s1[i];
					pin_s3[i] <= pin_s2[i];
				end
			end

			always_ff @(posedge CORE_CLK or negedge rst_n) begin
				if (!rst_n) begin
					pin_level[i] <= 1'b1;
					pin_prev[i]  <= 1'b1;
				end else begin
					if (pin_s2[i] == pin_s3[i]) begin
						pin_level[i] <= pin_s3[i];
					end
					pin_prev[i] <= pin_level[i];
				end
			end
		end
	endgenerate

	// the watchdog oscillator is free running; the main clock here only samples it,
	// so the oscillator must run well below CORE_CLK / 4
	assign osc_tick  = pin_level[PIN_OSC] && !pin_prev[PIN_OSC];
	assign master_clear_pin_fall = !pin_level[PIN_MASTER_CLEAR_PIN] && pin_prev[PIN_MASTER_CLEAR_PIN];

	// fuse byte is static after programming; sampled every cycle
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			fuse_cfg <= `WDSW_FUSE_RST;
		end else begin
			fuse_cfg <= WATCHDOG_CONFIG_BYTE;
		end
	end

	// soft bit only matters when the fuse leaves the watchdog off
	assign wdt_run = fuse_cfg[`WDSW_FUSE_EN_BIT] || soft_en;

	// APB: zero wait states, unmapped addresses answer with an error
	assign apb_write = PSEL && PENABLE && PWRITE;
	assign apb_read  = PSEL && !PWRITE;
	assign addr_hit  = is_mapped(PADDR);
	assign PREADY    = 1'b1;
	assign PSLVERR   = PSEL && PENABLE && !addr_hit;

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			soft_en <= 1'(`WDSW_CTL_RST);
		end else if (apb_write && PADDR == `WDSW_OFF_CONTROL) begin
			soft_en <= PWDATA[`WDSW_CTL_SOFT_EN_BIT];
		end
	end

	always_comb begin
		read_byte = 8'h00;
		case (PADDR)
			`WDSW_OFF_CONTROL: begin
				read_byte[`WDSW_CTL_SOFT_EN_BIT] = soft_en;
			end
			`WDSW_OFF_FUSE: begin
				read_byte = fuse_cfg;
			end
			`WDSW_OFF_CAUSE: begin
				read_byte[`WDSW_CAUSE_TO_BIT] = expiry_flag_n;
				read_byte[`WDSW_CAUSE_PD_BIT] = powerdown_flag_n;
			end
			`WDSW_OFF_STATUS: begin
				read_byte[`WDSW_STAT_SLEEP_BIT] = (state == ST_SLEEP);
				read_byte[`WDSW_STAT_RUN_BIT]   = wdt_run;
			end
			default: begin
				read_byte = 8'h00;
			end
		endcase
	end

	// read data registered in the setup cycle, valid through the access phase
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			PRDATA <= 32'h00000000;
		end else if (apb_read && !PENABLE) begin
			PRDATA <= {24'h000000, read_byte};
		end
	end

	// wake needs only the source's own enable, never the global one
	assign irq_pending = |(IRQ_FLAGS & IRQ_ENABLES);

	assign sleep_ignored = (state == ST_RUN) && SLEEP_INSTR && irq_pending;
	assign sleep_enter   = (state == ST_RUN) && SLEEP_INSTR && !irq_pending;
	assign sleep_wake    = (state == ST_SLEEP) &&
		(master_clear_pin_fall || irq_pending || (wdt_expire && wdt_run));

	// a no-op sleep leaves the counters alone
	assign wdt_clear = WATCHDOG_CLEAR_INSTR || sleep_enter;

	wdsw_counter #(
		.BASE_PERIOD (BASE_PERIOD),
		.CNT_W       (CNT_W)
	) u_counter (
		.clk       (CORE_CLK),
		.rst_n     (rst_n),
		.tick      (osc_tick),
		.clear     (wdt_clear),
		.run       (wdt_run),
		.scale_sel (fuse_cfg[`WDSW_FUSE_PS_LSB +: `WDSW_FUSE_PS_W]),
		.expire    (wdt_expire)
	);

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RUN;
		end else begin
			case (state)
				ST_RUN: begin
					if (sleep_enter) begin
						state <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (sleep_wake) begin
						state <= ST_RUN;
					end
				end
				default: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	// flags live across watchdog and master clear resets; power-up sets both, sleep entry also sets the expiry flag
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			expiry_flag_n <= 1'b1;
		end else if (wdt_expire && wdt_run) begin
			expiry_flag_n <= 1'b0;
		end else if (sleep_enter) begin
			expiry_flag_n <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			powerdown_flag_n <= 1'b1;
		end else if (sleep_enter) begin
			powerdown_flag_n <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			SLEEPING      <= 1'b0;
			OSC_DRIVER_ON <= 1'b1;
		end else if (sleep_enter) begin
			SLEEPING      <= 1'b1;
			OSC_DRIVER_ON <= 1'b0;
		end else if (sleep_wake) begin
			SLEEPING      <= 1'b0;
			OSC_DRIVER_ON <= 1'b1;
		end
	end

	// pin drivers follow the core while running and freeze in sleep
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			IO_DRIVE <= '0;
			IO_OE    <= '0;
		end else if (state == ST_RUN && !sleep_enter) begin
			IO_DRIVE <= IO_DRIVE_IN;
			IO_OE    <= IO_OE_IN;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			PREFETCH_ADDR <= '0;
		end else if (SLEEP_INSTR && state == ST_RUN) begin
			PREFETCH_ADDR <= PC_W'(PROGRAM_COUNTER + `WDSW_PC_STEP);
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			WATCHDOG_RESET <= 1'b0;
		end else begin
			WATCHDOG_RESET <= (state == ST_RUN) && wdt_expire && wdt_run;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			MASTER_CLEAR_RESET <= 1'b0;
		end else begin
			MASTER_CLEAR_RESET <= master_clear_pin_fall;
		end
	end

	// wake continues execution; master clear is a reset instead
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			WAKE        <= 1'b0;
			WAKE_BRANCH <= 1'b0;
		end else begin
			WAKE        <= sleep_wake && !master_clear_pin_fall;
			WAKE_BRANCH <= sleep_wake && !master_clear_pin_fall && irq_pending &&
				GLOBAL_IRQ_ENABLE;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			SLEEP_NOP <= 1'b0;
		end else begin
			SLEEP_NOP <= sleep_ignored;
		end
	end
endmodule // wdsw_top

// >>> wdsw_defines.svh
// register offsets, field positions, reset values for the watchdog/sleep block
`ifndef WDSW_DEFINES_SVH
`define WDSW_DEFINES_SVH
`define WDSW_ADDR_W          12
`define WDSW_OFF_CONTROL     12'h000
`define WDSW_OFF_FUSE        12'h004
`define WDSW_OFF_CAUSE       12'h008
`define WDSW_OFF_STATUS      12'h00C
`define WDSW_CTL_SOFT_EN_BIT 0
`define WDSW_CTL_RST         8'h00
`define WDSW_FUSE_EN_BIT     0
`define WDSW_FUSE_PS_LSB     1
`define WDSW_FUSE_PS_W       3
`define WDSW_FUSE_RST        8'h00
`define WDSW_CAUSE_TO_BIT    4
`define WDSW_CAUSE_PD_BIT    3
`define WDSW_STAT_SLEEP_BIT  0
`define WDSW_STAT_RUN_BIT    1
`define WDSW_PC_STEP         2
`define WDSW_PS_CNT_W        7
`endif

// >>> wdsw_pkg.sv
// types shared by the watchdog/sleep block
package wdsw_pkg;
	typedef enum logic [0:0] {
		ST_RUN,
		ST_SLEEP
	} wdsw_state_type;

	// sources able to wake the core: pin, port change, eleven clockless peripherals
	typedef struct packed {
		logic        ext_int;
		logic        port_b_change;
		logic [10:0] periph;
	} wdsw_wake_type;
endpackage

// >>> wdsw_counter.sv
// watchdog base counter and postscaler, advanced by ticks of the watchdog oscillator
`timescale 1ns/10ps
`include "wdsw_defines.svh"
module wdsw_counter #(
	parameter int BASE_PERIOD = 256,
	parameter int CNT_W       = 16
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       tick,
	input  wire logic       clear,
	input  wire logic       run,
	input  wire logic [2:0] scale_sel,
	output logic            expire
);
	logic [CNT_W-1:0]                base;
	logic [`WDSW_PS_CNT_W-1:0]       post;
	logic [`WDSW_PS_CNT_W-1:0]       post_limit;
	logic                            base_wrap;
	logic                            post_wrap;

	assign post_limit = `WDSW_PS_CNT_W'((1 << scale_sel) - 1);
	assign base_wrap  = run && tick && (base == CNT_W'(BASE_PERIOD - 1));
	assign post_wrap  = base_wrap && (post == post_limit);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			base <= '0;
		end else if (clear || !run) begin
			base <= '0;
		end else if (tick) begin
			base <= base_wrap ? '0 : CNT_W'(base + 1'b1);
		end
	end

	// clearing zeroes only the count; the ratio stays with the fuse byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			post <= '0;
		end else if (clear || !run) begin
			post <= '0;
		end else if (base_wrap) begin
			post <= post_wrap ? '0 : `WDSW_PS_CNT_W'(post + 1'b1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			expire <= 1'b0;
		end else begin
			expire <= post_wrap && !clear;
		end
	end
endmodule // wdsw_counter

// >>> wdsw_checker.sv
// port assertions for the watchdog and sleep block
`timescale 1ns/10ps
module wdsw_checker #(
	parameter int PC_W = 21,
	parameter int IO_W = 8
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic SLEEP_INSTR,
	input wire logic [PC_W-1:0] PROGRAM_COUNTER,
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic MASTER_CLEAR_PIN_N,
	input wire wdsw_pkg::wdsw_wake_type IRQ_FLAGS,
	input wire wdsw_pkg::wdsw_wake_type IRQ_ENABLES,
	input wire logic [IO_W-1:0] IO_DRIVE,
	input wire logic [IO_W-1:0] IO_OE,
	input wire logic [PC_W-1:0] PREFETCH_ADDR,
	input wire logic SLEEPING,
	input wire logic OSC_DRIVER_ON,
	input wire logic WATCHDOG_RESET,
	input wire logic MASTER_CLEAR_RESET,
	input wire logic WAKE,
	input wire logic WAKE_BRANCH,
	input wire logic SLEEP_NOP
);
	import wdsw_pkg::*;
	wire logic pend = |(IRQ_FLAGS & IRQ_ENABLES);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	a_sleep_entry: assert property (!SLEEPING && SLEEP_INSTR && !pend |=> SLEEPING &&
		!OSC_DRIVER_ON && PREFETCH_ADDR == $past(PROGRAM_COUNTER) + 2'd2)
		else $error("sleep entry wrong");
	a_sleep_nop: assert property (!SLEEPING && SLEEP_INSTR && pend |=> SLEEP_NOP && !SLEEPING)
		else $error("sleep not ignored");
	a_irq_wake: assert property (SLEEPING && pend |=> WAKE && !SLEEPING &&
		WAKE_BRANCH == $past(GLOBAL_IRQ_ENABLE))
		else $error("interrupt wake wrong");
	a_pins_held: assert property (SLEEPING && $past(SLEEPING) |-> $stable(IO_DRIVE) && $stable(IO_OE))
		else $error("pins moved in sleep");
	a_osc_off: assert property (OSC_DRIVER_ON != SLEEPING)
		else $error("oscillator driver wrong");
	a_wake_pulse: assert property (WAKE |-> $past(SLEEPING) && !SLEEPING ##1 !WAKE)
		else $error("wake pulse wrong");
	a_branch_wake: assert property (WAKE_BRANCH |-> WAKE)
		else $error("branch without wake");
	a_no_reset_sleep: assert property ($past(SLEEPING) |-> !WATCHDOG_RESET)
		else $error("watchdog reset in sleep");
	a_master_clear_pin_pulse: assert property ($fell(MASTER_CLEAR_PIN_N) |-> ##[2:12] MASTER_CLEAR_RESET)
		else $error("master clear lost");
endmodule // wdsw_checker

bind wdsw_top wdsw_checker #(.PC_W(PC_W), .IO_W(IO_W)) u_wdsw_checker (
	.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .SLEEP_INSTR(SLEEP_INSTR),
	.PROGRAM_COUNTER(PROGRAM_COUNTER), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
	.MASTER_CLEAR_PIN_N(MASTER_CLEAR_PIN_N), .IRQ_FLAGS(IRQ_FLAGS), .IRQ_ENABLES(IRQ_ENABLES),
	.IO_DRIVE(IO_DRIVE), .IO_OE(IO_OE), .PREFETCH_ADDR(PREFETCH_ADDR), .SLEEPING(SLEEPING),
	.OSC_DRIVER_ON(OSC_DRIVER_ON), .WATCHDOG_RESET(WATCHDOG_RESET),
	.MASTER_CLEAR_RESET(MASTER_CLEAR_RESET), .WAKE(WAKE), .WAKE_BRANCH(WAKE_BRANCH),
	.SLEEP_NOP(SLEEP_NOP));

// >>> wdsw_core_model.sv
// behavioural core that issues sleep and watchdog clear instructions
`timescale 1ns/10ps
module wdsw_core_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic req_sleep,
	input  wire logic req_clear,
	input  wire logic sleeping,
	output logic      sleep_instr,
	output logic      clear_instr,
	output logic [20:0] pc
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_instr <= 1'b0;
			clear_instr <= 1'b0;
			pc <= 21'h000100;
		end else begin
			// a stalled core executes nothing
			sleep_instr <= req_sleep && !sleeping;
			clear_instr <= req_clear && !sleeping;
			// a no-op follows each sleep, so the prefetched word is harmless
			if (!sleeping) begin
				pc <= pc + 21'h000002;
			end
		end
	end
endmodule // wdsw_core_model

// >>> test_watchdog_sleep_wake_control.sv
// self-checking bench for the watchdog, sleep and wake-up block
`timescale 1ns/10ps
module test_watchdog_sleep_wake_control;
	import wdsw_pkg::*;
	logic core_clk = 1'b0, reset_n = 1'b0, wosc = 1'b0, master_clear_pin_n = 1'b1, global_irq_enable = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go_sleep = 1'b0, go_clr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'h000118E9;
	logic [7:0] cfg = 8'h00, io_d = 8'h00, io_e = 8'h00, io_q, io_oe;
	wdsw_wake_type flg = '0, ena = '0;
	logic pready, pslverr, err, sl_i, clr_i, sleeping, osc_on, wd_rst, mc_rst, wake, wbr, snop;
	logic [20:0] pc, pf, pc_sl;
	int failures = 0, compares = 0, n_wdr = 0, n_wake = 0, n, base, m_to = 1, m_pd = 1;
	int osc_div = 0;
	wire logic [4:0] ev = {sleeping, snop, mc_rst, wd_rst, wake};
	wdsw_top #(.BASE_PERIOD(4)) u_wdsw_top (
		.CORE_CLK(core_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .WATCHDOG_CONFIG_BYTE(cfg), .WATCHDOG_OSC(wosc),
		.MASTER_CLEAR_PIN_N(master_clear_pin_n), .SLEEP_INSTR(sl_i), .WATCHDOG_CLEAR_INSTR(clr_i),
		.PROGRAM_COUNTER(pc), .GLOBAL_IRQ_ENABLE(global_irq_enable), .IRQ_FLAGS(flg), .IRQ_ENABLES(ena),
		.IO_DRIVE_IN(io_d), .IO_OE_IN(io_e), .IO_DRIVE(io_q), .IO_OE(io_oe),
		.PREFETCH_ADDR(pf), .SLEEPING(sleeping), .OSC_DRIVER_ON(osc_on),
		.WATCHDOG_RESET(wd_rst), .MASTER_CLEAR_RESET(mc_rst), .WAKE(wake),
		.WAKE_BRANCH(wbr), .SLEEP_NOP(snop));
	wdsw_core_model u_wdsw_core_model (
		.clk(core_clk), .rst_n(reset_n), .req_sleep(go_sleep), .req_clear(go_clr),
		.sleeping(sleeping), .sleep_instr(sl_i), .clear_instr(clr_i), .pc(pc));
	initial forever #2.5 core_clk = ~core_clk;
	// watchdog oscillator: period of 12 core cycles, driven like every other input
	always @(posedge core_clk) begin
		osc_div <= (osc_div == 5) ? 0 : osc_div + 1;
		if (osc_div == 5) begin
			wosc <= ~wosc;
		end
		// program counter of the last sleep, for the prefetch check
		if (sl_i) begin
			pc_sl <= pc;
		end
		n_wdr <= n_wdr + int'(wd_rst);
		n_wake <= n_wake + int'(wake);
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] cause_exp();
		return {27'h0, m_to[0], m_pd[0], 3'h0};
	endfunction
	task finish_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task report(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		report(got, exp);
	endtask
	task chk_pin(input logic got, input logic exp);
		report({31'h0, got}, {31'h0, exp});
	endtask
	task cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		i = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) begin
			failures++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk_reg(rd, exp);
	endtask
	task wait_ev(input int b);
		n = 0;
		while (ev[b] !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 3000) begin
			failures++;
			finish_test();
		end
	endtask
	task sleep_req;
		go_sleep <= 1'b1;
		@(posedge core_clk);
		go_sleep <= 1'b0;
	endtask
	task clr_req;
		go_clr <= 1'b1;
		@(posedge core_clk);
		go_clr <= 1'b0;
	endtask
	// expiry must land within one tick of k ticks after the clear
	task measure(input int k);
		clr_req();
		wait_ev(1);
		chk_pin(n >= (k - 1) * 12 && n <= k * 12 + 12, 1'b1);
		m_to = 0;
		cyc(1);
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		cyc(4);
		rd_chk(12'h000, 32'h0);
		apb(1'b1, 12'h008, 32'h0);
		rd_chk(12'h008, cause_exp());
		cfg <= 8'hF4;
		cyc(1);
		rd_chk(12'h004, 32'hF4);
		cfg <= 8'h00;
		apb(1'b0, 12'h010, 32'h0);
		chk_pin(err, 1'b1);
		repeat (4) begin
			rnd = lfsr(rnd);
			apb(1'b1, 12'h000, rnd);
			rd_chk(12'h000, {31'h0, rnd[0]});
		end
		apb(1'b1, 12'h000, 32'h0);
		base = n_wdr;
		cyc(300);
		chk_reg(n_wdr, base);
		apb(1'b1, 12'h000, 32'h1);
		measure(4);
		rd_chk(12'h008, cause_exp());
		apb(1'b1, 12'h000, 32'h0);
		for (int s = 0; s < 3; s++) begin
			cfg <= {4'h0, s[2:0], 1'b1};
			cyc(1);
			measure(4 << s);
		end
		cfg <= 8'h01;
		base = n_wdr;
		repeat (10) begin
			clr_req();
			cyc(20);
		end
		chk_reg(n_wdr, base);
		sleep_req();
		wait_ev(4);
		m_to = 1;
		m_pd = 0;
		rd_chk(12'h008, cause_exp());
		base = n_wdr;
		wait_ev(0);
		m_to = 0;
		chk_reg(n_wdr, base);
		cfg <= 8'h00;
		rd_chk(12'h008, cause_exp());
		flg <= wdsw_wake_type'(13'h1000);
		ena <= wdsw_wake_type'(13'h1000);
		cyc(1);
		sleep_req();
		wait_ev(3);
		cyc(2);
		chk_pin(sleeping, 1'b0);
		rd_chk(12'h008, cause_exp());
		flg <= '0;
		ena <= '0;
		for (int i = 0; i < 13; i++) begin
			rnd = lfsr(rnd);
			io_d <= rnd[7:0];
			io_e <= rnd[15:8];
			sleep_req();
			wait_ev(4);
			chk_reg({11'h0, pf}, {11'h0, pc_sl + 21'h000002});
			io_d <= ~rnd[7:0];
			io_e <= ~rnd[15:8];
			flg <= wdsw_wake_type'(13'h1 << i);
			global_irq_enable <= rnd[16];
			cyc(4);
			chk_pin(sleeping, 1'b1);
			chk_pin(osc_on, 1'b0);
			chk_reg({24'h0, io_q}, {24'h0, rnd[7:0]});
			chk_reg({24'h0, io_oe}, {24'h0, rnd[15:8]});
			ena <= flg;
			wait_ev(0);
			chk_pin(wbr, rnd[16]);
			flg <= '0;
			ena <= '0;
			cyc(2);
		end
		sleep_req();
		wait_ev(4);
		base = n_wake;
		master_clear_pin_n <= 1'b0;
		wait_ev(2);
		cyc(2);
		chk_pin(sleeping, 1'b0);
		chk_reg(n_wake, base);
		master_clear_pin_n <= 1'b1;
		cyc(20);
		finish_test();
	end
endmodule // test_watchdog_sleep_wake_control
